// *** hw/ifb_regs.vh ***
// register offsets, field positions and reset values of the interrupt
// flag and enable bank; included by the bank design file of the block
`ifndef IFB_REGS_VH
`define IFB_REGS_VH

// byte offsets on the 32-bit bus
`define IFB_OFF_MAIN     8'h00
`define IFB_OFF_EDGE     8'h04
`define IFB_OFF_EXT      8'h08
`define IFB_OFF_FLAG1    8'h0C
`define IFB_OFF_FLAG2    8'h10
`define IFB_OFF_FLAG3    8'h14
`define IFB_OFF_CFG      8'h18
`define IFB_OFF_STAT     8'h1C

// interrupt_main_control
`define IFB_MAIN_GIE     7
`define IFB_MAIN_PEIE    6
`define IFB_MAIN_T0IE    5
`define IFB_MAIN_X0IE    4
`define IFB_MAIN_PCIE    3
`define IFB_MAIN_T0IF    2
`define IFB_MAIN_X0IF    1
`define IFB_MAIN_PCIF    0

// interrupt_edge_pullup_control
`define IFB_EDGE_PUDIS   7
`define IFB_EDGE_X0EDG   6
`define IFB_EDGE_X1EDG   5
`define IFB_EDGE_X2EDG   4
`define IFB_EDGE_T0IP    2
`define IFB_EDGE_PCIP    0

// external_interrupt_control
`define IFB_EXT_X2IP     7
`define IFB_EXT_X1IP     6
`define IFB_EXT_X2IE     4
`define IFB_EXT_X1IE     3
`define IFB_EXT_X2IF     1
`define IFB_EXT_X1IF     0

// peripheral_request_flags_one
`define IFB_F1_PAR       7
`define IFB_F1_ADC       6
`define IFB_F1_RXF       5
`define IFB_F1_TXE       4
`define IFB_F1_SP1       3
`define IFB_F1_CC1       2
`define IFB_F1_T2M       1
`define IFB_F1_T1O       0

// peripheral_request_flags_two / three
`define IFB_F2_OSC       7
`define IFB_F2_CMP       6
`define IFB_F2_BC1       3
`define IFB_F2_CC2       0
`define IFB_F3_SP2       7
`define IFB_F3_BC2       6

// configuration and status
`define IFB_CFG_PRIORITY_SCHEME_ENABLE     7
`define IFB_STAT_MISM    2
`define IFB_STAT_LOW     1
`define IFB_STAT_HIGH    0

// reset values
`define IFB_RST_MAIN     8'h00
`define IFB_RST_EDGE     8'hF5
`define IFB_RST_EXT      8'hC0
`define IFB_RST_FLAG     8'h00

// implemented bits, for F1W the writable ones (its other bits are read-only levels); elsewhere the rest read zero and ignore writes
`define IFB_MASK_EDGE    8'hF5
`define IFB_MASK_EXT     8'hDB
`define IFB_MASK_F1W     8'hCF
`define IFB_MASK_F2      8'hC9
`define IFB_MASK_F3      8'hC0

`endif

// *** hw/ifb_edge_detect.v ***
// one external interrupt pin edge detector with selectable polarity
// assumes the pin is already synchronous to clk_sys
`timescale 1ns/1ns
module ifb_edge_detect (
  input  wire clk_sys,     // system clock
  input  wire resetn,      // async reset, active low
  input  wire pin,         // external interrupt pin level
  input  wire rising_sel,  // 1 rising edge, 0 falling edge
  output reg  edge_evt     // one-cycle pulse on selected edge
);

  reg pin_prev;
  reg primed;

  // first cycle after reset only samples, so no false edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_prev <= 1'b0;
      primed   <= 1'b0;
      edge_evt <= 1'b0;
    end else begin
      pin_prev <= pin;
      primed   <= 1'b1;
      if (rising_sel)
        edge_evt <= primed & pin & ~pin_prev;
      else
        edge_evt <= primed & ~pin & pin_prev;
    end
  end

endmodule // ifb_edge_detect

// *** hw/ifb_bank.v ***
// interrupt flag and enable bank with an APB register slave
// assumes event inputs are one-cycle pulses synchronous to clk_sys,
// level inputs are synchronous, and the core samples the requests.
// unmapped or unaligned accesses answer at once with pslverr set.
//
// Notes on behaviour
// [R1] Flags set on their event regardless of any enable or global bit.
// [R2] Global bit gates all; high-priority only when priority scheme on. Here it masks the low group as well when scheme on.
// [R3] Peripheral bit gates peripherals; low-priority group when scheme on.
// [R4] Timer-0, external-0 and port-change enables in main control.
// [R5] Timer-0 overflow flag sets on overflow, holds until software clear.
// [R6] External-0 flag sets on its edge, holds until software clear.
// [R7] Port-change flag sets when any upper port-B pin changes.
// [R8] Mismatch keeps setting flag; port-B read ends mismatch.
// [R9] Pull-up disable bit, one disables all pull-ups, resets to one.
// [R10] Edge select bits for external 0..2, one rising, reset one.
// [R11] Timer-0 and port-change priority bits, one high, reset one.
// [R12] External 2 and 1 priority bits, one high, reset one.
// [R13] External 2 and 1 enable bits, reset zero.
// [R14] External 2 and 1 flags set on edges, software cleared.
// [R15] Unimplemented bits read zero and ignore writes.
// [R16] Parallel port flag sets on access; absent on small variant.
// [R17] Conversion-done flag sets on completion, software cleared.
// [R18] Receive-full and transmit-empty flags are read-only levels.
// [R19] Sync serial port flags set on transfer completion.
// [R20] Capture/compare flags set on capture or match, not in PWM.
// [R21] Timer-2 match and timer-1 overflow flags, software cleared.
// [R22] Oscillator fail, comparator, bus collision flags, software cleared.
// [R23] Priority-enable bit selects single-level or two-level scheme.
// [R24] External interrupt 0 is always high priority.
// [R25] Write of zero clears a flag, but a same-cycle event wins.
`timescale 1ns/1ns
`include "ifb_regs.vh"
module ifb_bank #(
  parameter HAS_PARALLEL_PORT = 1  // 0 for the small-package variant
) (
  input  wire        clk_sys,              // system clock, 50 MHz
  input  wire        resetn,               // async reset, active low
  // APB slave
  input  wire        psel,                 // slave select
  input  wire        penable,              // access phase
  input  wire        pwrite,               // 1 write, 0 read
  input  wire [7:0]  paddr,                // byte address
  input  wire [31:0] pwdata,               // write data
  output reg  [31:0] prdata,               // read data
  output reg         pready,               // transfer done
  output reg         pslverr,              // unmapped address
  // core-side event sources
  input  wire        timer_zero_ovf_evt,   // timer-0 overflow pulse
  input  wire [2:0]  ext_irq_pins,         // external interrupt pins 0..2
  input  wire [7:4]  port_b_pins,          // upper port-B pin levels
  input  wire        port_b_read,          // software read of port B
  // peripheral event sources
  input  wire        parallel_port_evt,    // parallel port access pulse
  input  wire        adc_done_evt,         // conversion complete pulse
  input  wire        serial_rx_full,       // receive buffer full level
  input  wire        serial_tx_empty,      // transmit buffer empty level
  input  wire        sync_port_one_evt,    // serial port 1 done pulse
  input  wire        capcomp_one_evt,      // capture/match 1 pulse
  input  wire        capcomp_one_pwm,      // unit 1 in PWM mode
  input  wire        timer_two_match_evt,  // timer-2 period match pulse
  input  wire        timer_one_ovf_evt,    // timer-1 overflow pulse
  input  wire        osc_fail_evt,         // clock fail, changeover pulse
  input  wire        comparator_evt,       // comparator change pulse
  input  wire        bus_collision_one_evt,// serial port 1 collision
  input  wire        capcomp_two_evt,      // capture/match 2 pulse
  input  wire        capcomp_two_pwm,      // unit 2 in PWM mode
  input  wire        sync_port_two_evt,    // serial port 2 done pulse
  input  wire        bus_collision_two_evt,// serial port 2 collision
  input  wire        periph_pend_high,     // enabled high-prio periph flag
  input  wire        periph_pend_low,      // enabled low-prio periph flag
  // outputs to core and port
  output reg         irq_high_req,         // request to high vector
  output reg         irq_low_req,          // request to low vector
  output reg         port_pullup_disable   // all port-B pull-ups off
);

  reg  [7:0] main_ctl;
  reg  [7:0] edge_ctl;
  reg  [7:0] ext_ctl;
  reg  [7:0] flags_one;
  reg  [7:0] flags_two;
  reg  [7:0] flags_three;
  reg        priority_scheme_enable;
  reg  [7:4] port_latch;
  reg        port_primed;

  reg  [7:0] next_main;
  reg  [7:0] next_edge;
  reg  [7:0] next_ext;
  reg  [7:0] next_flags_one;
  reg  [7:0] next_flags_two;
  reg  [7:0] next_flags_three;
  reg  [31:0] next_rdata;
  reg        next_err;
  reg        next_high;
  reg        next_low;

  wire [2:0] ext_edge_evt;
  wire [2:0] edge_sel;
  wire       wr_access;
  wire       setup;
  wire       mismatch;
  wire       addr_ok;

  // edge select bits for external 0, 1, 2
  assign edge_sel = {edge_ctl[`IFB_EDGE_X2EDG], edge_ctl[`IFB_EDGE_X1EDG],
                     edge_ctl[`IFB_EDGE_X0EDG]};

  // [R10] edge select per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
      ifb_edge_detect u_edge (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .pin        (ext_irq_pins[gi]),
        .rising_sel (edge_sel[gi]),
        .edge_evt   (ext_edge_evt[gi])
      );
    end
  endgenerate

  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pready & pwrite;
  assign addr_ok   = (paddr[1:0] == 2'b00) && (paddr <= `IFB_OFF_STAT);

  // [R8] mismatch against the value latched at the last port-B read
  assign mismatch = port_primed & (port_b_pins != port_latch);

  // latch loads in the first cycle after reset, so the pin levels
  // present at reset never count as a change
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port_latch  <= 4'h0;
      port_primed <= 1'b0;
    end else begin
      port_primed <= 1'b1;
      // [R8] read ends mismatch
      if (port_b_read || !port_primed)
        port_latch <= port_b_pins;
    end
  end

  // flag and control next values; events applied after the write so a
  // same-cycle set overrides a software clear
  always @* begin
    next_main        = main_ctl;
    next_edge        = edge_ctl;
    next_ext         = ext_ctl;
    next_flags_one   = flags_one;
    next_flags_two   = flags_two;
    next_flags_three = flags_three;
    if (wr_access) begin
      case (paddr)
        // [R4] enables written directly
        `IFB_OFF_MAIN:  next_main = pwdata[7:0];
        // [R15] unimplemented bits dropped
        `IFB_OFF_EDGE:  next_edge = pwdata[7:0] & `IFB_MASK_EDGE;
        `IFB_OFF_EXT:   next_ext  = pwdata[7:0] & `IFB_MASK_EXT;
        `IFB_OFF_FLAG1: next_flags_one =
                          (pwdata[7:0] & `IFB_MASK_F1W) |
                          (flags_one & ~`IFB_MASK_F1W);
        `IFB_OFF_FLAG2: next_flags_two = pwdata[7:0] & `IFB_MASK_F2;
        `IFB_OFF_FLAG3: next_flags_three = pwdata[7:0] & `IFB_MASK_F3;
        // cfg has its own flop below; stat is read-only
        default: ;
      endcase
    end
    // [R1] [R25] events set flags whatever the enables, set wins
    // [R5] timer-0 overflow
    if (timer_zero_ovf_evt)
      next_main[`IFB_MAIN_T0IF] = 1'b1;
    // [R6] external 0 edge
    if (ext_edge_evt[0])
      next_main[`IFB_MAIN_X0IF] = 1'b1;
    // [R7] [R8] port change, held while mismatch stands
    if (mismatch)
      next_main[`IFB_MAIN_PCIF] = 1'b1;
    // [R14] external 1 and 2 edges
    if (ext_edge_evt[1])
      next_ext[`IFB_EXT_X1IF] = 1'b1;
    if (ext_edge_evt[2])
      next_ext[`IFB_EXT_X2IF] = 1'b1;
    // [R16] parallel port access
    if (HAS_PARALLEL_PORT == 0)
      next_flags_one[`IFB_F1_PAR] = 1'b0;
    else if (parallel_port_evt)
      next_flags_one[`IFB_F1_PAR] = 1'b1;
    // [R17] conversion done
    if (adc_done_evt)
      next_flags_one[`IFB_F1_ADC] = 1'b1;
    // [R18] read-only buffer levels
    next_flags_one[`IFB_F1_RXF] = serial_rx_full;
    next_flags_one[`IFB_F1_TXE] = serial_tx_empty;
    // [R19] serial transfer done
    if (sync_port_one_evt)
      next_flags_one[`IFB_F1_SP1] = 1'b1;
    if (sync_port_two_evt)
      next_flags_three[`IFB_F3_SP2] = 1'b1;
    // [R20] capture or match, ignored in PWM mode
    if (capcomp_one_evt && !capcomp_one_pwm)
      next_flags_one[`IFB_F1_CC1] = 1'b1;
    if (capcomp_two_evt && !capcomp_two_pwm)
      next_flags_two[`IFB_F2_CC2] = 1'b1;
    // [R21] timer match and overflow
    if (timer_two_match_evt)
      next_flags_one[`IFB_F1_T2M] = 1'b1;
    if (timer_one_ovf_evt)
      next_flags_one[`IFB_F1_T1O] = 1'b1;
    // [R22] clock fail, comparator, collisions
    if (osc_fail_evt)
      next_flags_two[`IFB_F2_OSC] = 1'b1;
    if (comparator_evt)
      next_flags_two[`IFB_F2_CMP] = 1'b1;
    if (bus_collision_one_evt)
      next_flags_two[`IFB_F2_BC1] = 1'b1;
    if (bus_collision_two_evt)
      next_flags_three[`IFB_F3_BC2] = 1'b1;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      main_ctl               <= `IFB_RST_MAIN;
      edge_ctl               <= `IFB_RST_EDGE;
      ext_ctl                <= `IFB_RST_EXT;
      flags_one              <= `IFB_RST_FLAG;
      flags_two              <= `IFB_RST_FLAG;
      flags_three            <= `IFB_RST_FLAG;
      priority_scheme_enable <= 1'b0;
    end else begin
      main_ctl    <= next_main;
      edge_ctl    <= next_edge;
      ext_ctl     <= next_ext;
      flags_one   <= next_flags_one;
      flags_two   <= next_flags_two;
      flags_three <= next_flags_three;
      // [R23] scheme select
      if (wr_access && paddr == `IFB_OFF_CFG)
        priority_scheme_enable <= pwdata[`IFB_CFG_PRIORITY_SCHEME_ENABLE];
    end
  end

  // request decode; core sources pending when flag and enable both set
  // peripheral enables and priorities live outside; they arrive as
  // the two periph_pend levels
  reg t0_pend;
  reg x0_pend;
  reg pc_pend;
  reg x1_pend;
  reg x2_pend;
  reg core_high;
  reg core_low;

  always @* begin
    t0_pend = main_ctl[`IFB_MAIN_T0IF] & main_ctl[`IFB_MAIN_T0IE];
    x0_pend = main_ctl[`IFB_MAIN_X0IF] & main_ctl[`IFB_MAIN_X0IE];
    pc_pend = main_ctl[`IFB_MAIN_PCIF] & main_ctl[`IFB_MAIN_PCIE];
    // [R13] external 1 and 2 enables
    x1_pend = ext_ctl[`IFB_EXT_X1IF] & ext_ctl[`IFB_EXT_X1IE];
    x2_pend = ext_ctl[`IFB_EXT_X2IF] & ext_ctl[`IFB_EXT_X2IE];
    // [R24] external 0 always high
    // [R11] [R12] priority bits route sources
    core_high = x0_pend
              | (t0_pend & edge_ctl[`IFB_EDGE_T0IP])
              | (pc_pend & edge_ctl[`IFB_EDGE_PCIP])
              | (x1_pend & ext_ctl[`IFB_EXT_X1IP])
              | (x2_pend & ext_ctl[`IFB_EXT_X2IP]);
    core_low  = (t0_pend & ~edge_ctl[`IFB_EDGE_T0IP])
              | (pc_pend & ~edge_ctl[`IFB_EDGE_PCIP])
              | (x1_pend & ~ext_ctl[`IFB_EXT_X1IP])
              | (x2_pend & ~ext_ctl[`IFB_EXT_X2IP]);
    // [R23] scheme select
    if (!priority_scheme_enable) begin
      // [R2] [R3] single level: global over all, peripheral over group
      // priority bits have no effect in this scheme
      next_high = main_ctl[`IFB_MAIN_GIE] &
                  (core_high | core_low |
                   (main_ctl[`IFB_MAIN_PEIE] &
                    (periph_pend_high | periph_pend_low)));
      next_low  = 1'b0;
    end else begin
      // [R2] [R3] two level: high bit gates all, low bit its group
      next_high = main_ctl[`IFB_MAIN_GIE] &
                  (core_high | periph_pend_high);
      // [R2] a clear global bit masks the low group as well
      next_low  = main_ctl[`IFB_MAIN_GIE] & main_ctl[`IFB_MAIN_PEIE] &
                  (core_low | periph_pend_low);
    end
  end

  // read mux sampled in the setup cycle
  // a flag set during the access cycle shows on the next read
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = ~addr_ok;
    case (paddr)
      `IFB_OFF_MAIN:  next_rdata[7:0] = main_ctl;
      // [R15] reserved bits read zero
      `IFB_OFF_EDGE:  next_rdata[7:0] = edge_ctl & `IFB_MASK_EDGE;
      `IFB_OFF_EXT:   next_rdata[7:0] = ext_ctl & `IFB_MASK_EXT;
      `IFB_OFF_FLAG1: next_rdata[7:0] = flags_one;
      `IFB_OFF_FLAG2: next_rdata[7:0] = flags_two & `IFB_MASK_F2;
      `IFB_OFF_FLAG3: next_rdata[7:0] = flags_three & `IFB_MASK_F3;
      `IFB_OFF_CFG:   next_rdata[`IFB_CFG_PRIORITY_SCHEME_ENABLE] = priority_scheme_enable;
      // stat shows the registered requests, one cycle behind flags
      `IFB_OFF_STAT: begin
        next_rdata[`IFB_STAT_MISM] = mismatch;
        next_rdata[`IFB_STAT_LOW]  = irq_low_req;
        next_rdata[`IFB_STAT_HIGH] = irq_high_req;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // no wait state, yet every bus output comes from a flop loaded in setup
  // refused accesses answer just as fast, so the bus never stalls
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      irq_high_req        <= 1'b0;
      irq_low_req         <= 1'b0;
      port_pullup_disable <= 1'b1;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
      // requests registered so the core sees glitch-free levels
      irq_high_req <= next_high;
      irq_low_req  <= next_low;
      // [R9] pull-up disable follows its bit
      port_pullup_disable <= edge_ctl[`IFB_EDGE_PUDIS];
    end
  end

endmodule // ifb_bank

// *** dv/ifb_bank_assertions.sv ***
// checker for the register slave handshake and pull-up output
// bound to every ifb_bank instance; sees its ports only
`timescale 1ns/1ns
module ifb_bank_assertions (
  input wire logic        clk_sys,             // system clock
  input wire logic        resetn,              // async reset
  input wire logic        psel,                // slave select
  input wire logic        penable,             // access phase
  input wire logic        pwrite,              // direction
  input wire logic [7:0]  paddr,               // byte address
  input wire logic [31:0] pwdata,              // write data
  input wire logic [31:0] prdata,              // read data
  input wire logic        pready,              // transfer done
  input wire logic        pslverr,             // unmapped address
  input wire logic        irq_high_req,        // high request
  input wire logic        irq_low_req,         // low request
  input wire logic        port_pullup_disable  // pull-ups off
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire setup = psel && !penable;
  wire bad   = (paddr > 8'h1C) || (paddr[1:0] != 2'b00);

  a_ready_next: assert property (setup |=> pready && penable)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (setup && bad |=> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && !bad |=> !pslverr)
    else $error("mapped access refused");
  a_err_rdzero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0) else $error("refused read not zero");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pullup_rst: assert property (!$past(resetn) |-> port_pullup_disable)
    else $error("pull-up disable not set after reset");
  a_irq_rst: assert property (!$past(resetn)
    |-> !irq_high_req && !irq_low_req) else $error("request after reset");
  a_pullup_wr: assert property (pready && penable && pwrite
    && paddr == 8'h04 |=> ##1 port_pullup_disable == $past(pwdata[7], 2))
    else $error("pull-up disable not following its bit");
  a_stat_irq: assert property (pready && !pwrite && !pslverr
    && paddr == 8'h1C |-> prdata[1] == $past(irq_low_req)
    && prdata[0] == $past(irq_high_req))
    else $error("status bits differ from request outputs");

  c_refused: cover property (pready && pslverr);
  c_low_req: cover property (irq_low_req);
  c_high_req: cover property (irq_high_req && !irq_low_req);
endmodule // ifb_bank_assertions

bind ifb_bank ifb_bank_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_high_req(irq_high_req), .irq_low_req(irq_low_req),
  .port_pullup_disable(port_pullup_disable));

// *** dv/ifb_src_model.sv ***
// model of the peripheral event sources beside the flag bank
// the bench asks for events through one request word per cycle
`timescale 1ns/1ns
module ifb_src_model (
  input  wire logic        clk_sys,  // system clock
  input  wire logic [11:0] fire,     // event requests
  input  wire logic [1:0]  lvl,      // rx full, tx empty wanted
  output logic      [11:0] evt,      // one-cycle event pulses
  output logic      [1:0]  buf_lvl   // buffer status levels
);
  // events raised whatever the enables hold
  always @(posedge clk_sys) begin
    evt     <= fire & ~evt;
    buf_lvl <= lvl;
  end
endmodule // ifb_src_model

// *** dv/ifb_bank_tb.sv ***
// self-checking bench of the interrupt flag and enable bank
// apb master tasks note expected reads; a monitor compares them
`timescale 1ns/1ns
module ifb_bank_tb;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rnd = 32'h7312;
  logic tmr0 = 0, pbrd = 0, ph = 0, pl = 0;
  logic [2:0] xp = 0;
  logic [7:4] pb = 0;
  logic [11:0] fire = 0;
  logic [1:0] lvl = 0, pwm = 0, bl;
  wire [31:0] prdata;
  wire pready, pslverr, irqh, irql, pud;
  wire [11:0] evt;
  int error_cnt = 0, comparisons = 0, i;
  logic [32:0] q[$];
  logic [7:0] ro[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [7:0] rm[7] = '{8'hFF, 8'hF5, 8'hDB, 8'hCF, 8'hC9, 8'hC0, 8'h80};
  logic [7:0] rr[7] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
  int eb[12] = '{7, 6, 3, 2, 1, 0, 7, 6, 3, 0, 7, 6};

  ifb_bank u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_zero_ovf_evt(tmr0), .ext_irq_pins(xp), .port_b_pins(pb),
    .port_b_read(pbrd), .parallel_port_evt(evt[0]), .adc_done_evt(evt[1]),
    .serial_rx_full(bl[1]), .serial_tx_empty(bl[0]),
    .sync_port_one_evt(evt[2]), .capcomp_one_evt(evt[3]),
    .capcomp_one_pwm(pwm[0]), .timer_two_match_evt(evt[4]),
    .timer_one_ovf_evt(evt[5]), .osc_fail_evt(evt[6]),
    .comparator_evt(evt[7]), .bus_collision_one_evt(evt[8]),
    .capcomp_two_evt(evt[9]), .capcomp_two_pwm(pwm[1]),
    .sync_port_two_evt(evt[10]), .bus_collision_two_evt(evt[11]),
    .periph_pend_high(ph), .periph_pend_low(pl), .irq_high_req(irqh),
    .irq_low_req(irql), .port_pullup_disable(pud));
  ifb_src_model u_src (.clk_sys(clk_sys), .fire(fire), .lvl(lvl),
    .evt(evt), .buf_lvl(bl));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] eoff(input int k);
    return k < 6 ? 8'h0C : (k < 10 ? 8'h10 : 8'h14);
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // request held until pready is sampled, then released
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // only the watchdog ends a wait for the answer
    do @(posedge clk_sys);
    while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit er = 0);
    q.push_back({er, 24'h0, e});
    apb(a, 0, 0);
  endtask
  task automatic ev(input int k);
    fire <= 12'h1 << k;
    @(posedge clk_sys);
    fire <= 0;
    cyc(4);
  endtask
  task automatic rst_vals;
    for (i = 0; i < 7; i++) rd(ro[i], rr[i]);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, q.pop_front());

  initial begin
    #400000;
    error_cnt++;
    finish_test;
  end

  initial begin
    cyc(2);
    resetn <= 1;
    @(posedge clk_sys);
    rst_vals;
    for (i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      wr(ro[i], rnd);
      rd(ro[i], rnd[7:0] & rm[i]);
      wr(ro[i], 0);
      rd(ro[i], 0);
    end
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 0);
    rd(8'h20, 0, 1);
    rd(8'h05, 0, 1);
    for (i = 0; i < 12; i++) begin
      ev(i);
      rd(eoff(i), 8'h1 << eb[i]);
      wr(eoff(i), 0);
      rd(eoff(i), 0);
    end
    pwm <= 2'b11;
    ev(3);
    ev(9);
    rd(8'h0C, 0);
    rd(8'h10, 0);
    pwm <= 0;
    lvl <= 2'b11;
    cyc(3);
    rd(8'h0C, 8'h30);
    wr(8'h0C, 0);
    rd(8'h0C, 8'h30);
    lvl <= 0;
    cyc(3);
    rd(8'h0C, 0);
    tmr0 <= 1;
    @(posedge clk_sys);
    tmr0 <= 0;
    cyc(3);
    rd(8'h00, 8'h04);
    fork
      wr(8'h00, 0);
      begin
        @(posedge clk_sys);
        tmr0 <= 1;
        @(posedge clk_sys);
        tmr0 <= 0;
      end
    join
    rd(8'h00, 8'h04);
    wr(8'h00, 8'hA4);
    cyc(2);
    rd(8'h1C, 8'h01);
    wr(8'h00, 8'h24);
    cyc(2);
    rd(8'h1C, 0);
    pl <= 1;
    wr(8'h00, 8'hC0);
    cyc(2);
    rd(8'h1C, 8'h01);
    wr(8'h00, 8'h80);
    cyc(2);
    rd(8'h1C, 0);
    pl <= 0;
    wr(8'h18, 8'h80);
    wr(8'h04, 8'hF1);
    wr(8'h00, 8'hE4);
    cyc(2);
    rd(8'h1C, 8'h02);
    wr(8'h00, 8'h64);
    cyc(2);
    rd(8'h1C, 0);
    wr(8'h00, 8'h92);
    ph <= 1;
    cyc(2);
    rd(8'h1C, 8'h01);
    ph <= 0;
    wr(8'h00, 0);
    wr(8'h18, 0);
    wr(8'h08, 8'hC0);
    wr(8'h04, 8'hF5);
    xp <= 3'h7;
    cyc(4);
    rd(8'h00, 8'h02);
    rd(8'h08, 8'hC3);
    wr(8'h00, 0);
    wr(8'h08, 8'hC0);
    wr(8'h04, 8'h85);
    xp <= 0;
    cyc(4);
    rd(8'h00, 8'h02);
    rd(8'h08, 8'hC3);
    wr(8'h00, 0);
    wr(8'h08, 8'hC0);
    xp <= 3'h7;
    cyc(4);
    rd(8'h00, 0);
    rd(8'h08, 8'hC0);
    pb <= 4'h5;
    cyc(3);
    rd(8'h00, 8'h01);
    rd(8'h1C, 8'h04);
    wr(8'h00, 0);
    rd(8'h00, 8'h01);
    pbrd <= 1;
    @(posedge clk_sys);
    pbrd <= 0;
    wr(8'h00, 0);
    rd(8'h00, 0);
    rd(8'h1C, 0);
    resetn <= 0;
    cyc(2);
    resetn <= 1;
    @(posedge clk_sys);
    rst_vals;
    finish_test;
  end
endmodule // ifb_bank_tb
